// ---- rtl/clb_top.sv ----
// clb_top: configurable logic block with four lookup tables in two pairs,
// byte register port, source selection, clock choice, flags and request.
// assumes sources and oscillators are asynchronous; standby comes from
// the sleep controller on ref_clk.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "clb_map.svh"

// Functional notes
// - standby-run bit 6 keeps the block running during standby sleep.
// - global enable bit 0 enables the whole block.
// - low pair sequencer: off, data flop, J-K flop, data latch, set/reset latch.
// - high pair sequencer uses the same five codes; higher codes reserved.
// - per-table sense field: none, rising, falling or both edges.
// - a table flag sets when its output changes as its sense selects.
// - writing one to a flag bit clears it; zero leaves it.
// - bit 7 of table control enables that table's edge detector.
// - bit 6 drives the table output onto its own pin, overriding port.
// - filter field: none, synchronizer, filter; code three reserved.
// - clock field: peripheral, input 2, fast, 32 kHz, 1 kHz oscillators.
// - each pair's sequencer uses the even table's clock choice.
// - input 1 select picks masked, feedback, link, events, pin and peripherals.
// - input 0 select uses the same codes with index-0 sources.
// - truth bit k gives the output when the inputs read as k.
// - all flags combine into one request held while any is set.
module clb_top (
  // clock, reset, clock enable
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  // register port
  input  wire clb_pkg::clb_bus_req_s bus_req,
  output var  logic [7:0]            rdata_q,
  // sleep controller
  input  wire logic                  standby,
  // signal sources
  input  wire clb_pkg::clb_src_s [3:0] src,
  input  wire logic                  analog_comparator_out,
  input  wire clb_pkg::clb_osc_s     osc,
  // table outputs and pins
  output var  logic [3:0]            table_output_q,
  output var  logic [3:0]            pin_out_q,
  output var  logic [3:0]            pin_output_enable_q,
  // combined interrupt request
  output var  logic                  irq_q
);
  import clb_pkg::*;

  localparam int SYNC_W = 4 * $bits(clb_src_s) + 1 + $bits(clb_osc_s);

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;

    logic [7:0]        ctrl;
    logic [3:0]        seq_lo;
    logic [3:0]        seq_hi;
    logic [7:0]        sense;
    logic [3:0]        flags;

    logic [3:0][7:0]   tctl_a;
    logic [3:0][7:0]   tctl_b;
    logic [3:0][7:0]   tctl_c;
    logic [3:0][7:0]   truth;

    logic [2:0]        osc_prev;
    logic [3:0]        in2_prev;
    logic [7:0]        rdata;
    logic [3:0]        out;
    logic [3:0]        pin_out;
    logic [3:0]        oe;
    logic              irq;
  } clb_top_state_s;

  clb_top_state_s  state_q;
  clb_top_state_s  state_d;

  // synchronised views of the asynchronous inputs
  clb_src_s [3:0]  src_s;
  logic            cmp_s;
  clb_osc_s        osc_s;

  logic            run;
  logic [3:0]      tbl_run;
  logic [3:0]      tick;
  logic [3:0]      cond;
  logic [3:0][2:0] in_bits;
  logic [1:0]      seq_active;
  logic [1:0]      seq_q;
  logic [3:0]      out_next;

  // register decode
  logic            in_tbl;
  logic [2:0]      tix_full;
  logic [1:0]      tix;
  logic [1:0]      sub;
  logic            prot;

  assign {src_s, cmp_s, osc_s} = state_q.sync2;

  // standby stops the block unless standby-run is set
  assign run = state_q.ctrl[`CLB_CTRL_EN]
               && (!standby || state_q.ctrl[`CLB_CTRL_STDBY]);

  // table group: address bits 4:2 pick the table, bits 1:0 its register
  assign in_tbl   = (bus_req.addr >= `CLB_OFF_TBL_FIRST)
                    && (bus_req.addr <= `CLB_OFF_TBL_LAST);
  assign tix_full = bus_req.addr[4:2] - `CLB_TBL_BASE_IDX;
  assign tix      = tix_full[1:0];
  assign sub      = bus_req.addr[1:0];
  // the global enable alone guards every protected register
  assign prot     = state_q.ctrl[`CLB_CTRL_EN];

  // one source pick per input; k is the input index
  function automatic logic src_pick(
    input logic [3:0] code,
    input logic [1:0] k,
    input clb_src_s   s,
    input logic       fb,
    input logic       link,
    input logic       cmp
  );
    logic r;

    r = 1'b0;
    case (code)
      `CLB_SRC_MASK:     r = 1'b0;
      `CLB_SRC_FEEDBACK: r = fb;
      `CLB_SRC_LINK:     r = link;
      `CLB_SRC_EV_A:     r = s.event_a;
      `CLB_SRC_EV_B:     r = s.event_b;
      `CLB_SRC_PIN:      r = s.pin[k];
      `CLB_SRC_CMP:      r = cmp;
      // serial sources only meaningful in host modes
      `CLB_SRC_SERIAL:   r = s.serial_tx[k];
      `CLB_SRC_SPI:      r = s.spi[k];
      `CLB_SRC_TIMER_A:  r = s.timer_a[k];
      `CLB_SRC_TIMER_B:  r = s.timer_b[k];
      default:           r = 1'b0;
    endcase
    return r;
  endfunction : src_pick

  genvar gn;
  generate
    for (gn = 0; gn < 4; gn++) begin : g_tbl
      localparam int LINK = (gn + 1) % 4;
      localparam int EVEN = gn - (gn % 2);
      logic       fb;
      logic [3:0] sel0;
      logic [3:0] sel1;
      logic [3:0] sel2;
      logic       in2_rise;

      // feedback comes from the pair output, registered to avoid loops
      assign fb   = state_q.out[EVEN];
      assign sel0 = state_q.tctl_b[gn][`CLB_IN0_LSB +: 4];
      assign sel1 = state_q.tctl_b[gn][`CLB_IN1_LSB +: 4];
      assign sel2 = state_q.tctl_c[gn][3:0];

      assign in_bits[gn][0] = src_pick(sel0, 2'h0, src_s[gn], fb, state_q.out[LINK], cmp_s);
      assign in_bits[gn][1] = src_pick(sel1, 2'h1, src_s[gn], fb, state_q.out[LINK], cmp_s);
      assign in_bits[gn][2] = src_pick(sel2, 2'h2, src_s[gn], fb, state_q.out[LINK], cmp_s);

      assign in2_rise = in_bits[gn][2] & ~state_q.in2_prev[gn];

      // selected clock becomes a one-cycle enable on ref_clk
      // reserved codes never tick, which freezes that table's filter
      always_comb begin
        case (state_q.tctl_a[gn][`CLB_TA_CLK_LSB +: 3])
          `CLB_CLK_SYS:  tick[gn] = 1'b1;
          `CLB_CLK_IN2:  tick[gn] = in2_rise;
          `CLB_CLK_FAST: tick[gn] = osc_s.fast & ~state_q.osc_prev[2];
          `CLB_CLK_32K:  tick[gn] = osc_s.slow_32k & ~state_q.osc_prev[1];
          `CLB_CLK_1K:   tick[gn] = osc_s.slow_1k & ~state_q.osc_prev[0];
          default:       tick[gn] = 1'b0;
        endcase
      end

      assign tbl_run[gn] = run && state_q.tctl_a[gn][`CLB_TA_EN];

      clb_lut u_lut (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .ce       (ce),
        .run      (tbl_run[gn]),
        .tick     (tick[gn]),
        .truth    (state_q.truth[gn]),
        .filt_sel (state_q.tctl_a[gn][`CLB_TA_FILT_LSB +: 2]),
        .edge_en  (state_q.tctl_a[gn][`CLB_TA_EDGE]),
        .in_bits  (in_bits[gn]),
        .cond_out (cond[gn])
      );
    end

    for (gn = 0; gn < 2; gn++) begin : g_pair
      clb_seq u_seq (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .run     (run),
        .tick    (tick[2*gn]),
        .mode    (gn == 0 ? state_q.seq_lo : state_q.seq_hi),
        .a       (cond[2*gn]),
        .b       (cond[2*gn+1]),
        .active  (seq_active[gn]),
        .q       (seq_q[gn])
      );

      // sequencer result replaces the even table's output
      assign out_next[2*gn]   = run && (seq_active[gn] ? seq_q[gn] : cond[2*gn]);
      assign out_next[2*gn+1] = run && cond[2*gn+1];
    end
  endgenerate

  always_comb begin
    logic [3:0] rise;
    logic [3:0] fall;
    logic [3:0] set;
    logic [3:0] clr;
    logic [1:0] mode;

    rise = 4'h0;
    fall = 4'h0;
    set = 4'h0;
    clr = 4'h0;
    mode = 2'h0;
    state_d = state_q;

    // input synchronisers
    state_d.sync1 = {src, analog_comparator_out, osc};
    state_d.sync2 = state_q.sync1;
    state_d.osc_prev = {osc_s.fast, osc_s.slow_32k, osc_s.slow_1k};
    for (int n = 0; n < 4; n++) begin
      state_d.in2_prev[n] = in_bits[n][2];
    end

    // register writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        `CLB_OFF_CTRL: begin
          state_d.ctrl = bus_req.wdata & 8'h41;
        end
        `CLB_OFF_SEQ_LO: begin
          if (!prot) begin
            state_d.seq_lo = bus_req.wdata[3:0];
          end
        end
        `CLB_OFF_SEQ_HI: begin
          if (!prot) begin
            state_d.seq_hi = bus_req.wdata[3:0];
          end
        end
        `CLB_OFF_SENSE: begin
          state_d.sense = bus_req.wdata;
        end
        `CLB_OFF_FLAGS: begin
          clr = bus_req.wdata[3:0];
        end
        default: begin
          if (in_tbl && !prot) begin
            case (sub)
              `CLB_SUB_CTRL_A: state_d.tctl_a[tix] = bus_req.wdata;
              `CLB_SUB_INSEL:  state_d.tctl_b[tix] = bus_req.wdata;
              `CLB_SUB_INSEL2: state_d.tctl_c[tix] = {4'h0, bus_req.wdata[3:0]};
              default:         state_d.truth[tix] = bus_req.wdata;
            endcase
          end
        end
      endcase
    end

    // outputs and flags
    rise = out_next & ~state_q.out;
    fall = ~out_next & state_q.out;
    for (int n = 0; n < 4; n++) begin
      mode = state_q.sense[2*n +: 2];
      case (mode)
        `CLB_SENSE_RISE: set[n] = rise[n];
        `CLB_SENSE_FALL: set[n] = fall[n];
        `CLB_SENSE_BOTH: set[n] = rise[n] | fall[n];
        default:         set[n] = 1'b0;
      endcase
    end

    if (!run) begin
      set = 4'h0;
    end

    // a new edge wins over a clear in the same cycle
    state_d.flags = (state_q.flags & ~clr) | set;
    state_d.irq = |state_d.flags;
    state_d.out = out_next;

    for (int n = 0; n < 4; n++) begin
      state_d.oe[n] = tbl_run[n] && state_d.tctl_a[n][`CLB_TA_OE];
      state_d.pin_out[n] = state_d.oe[n] && out_next[n];
    end

    // register reads, data in the following cycle
    state_d.rdata = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        `CLB_OFF_CTRL:   state_d.rdata = state_q.ctrl;
        `CLB_OFF_SEQ_LO: state_d.rdata = {4'h0, state_q.seq_lo};
        `CLB_OFF_SEQ_HI: state_d.rdata = {4'h0, state_q.seq_hi};
        `CLB_OFF_SENSE:  state_d.rdata = state_q.sense;
        `CLB_OFF_FLAGS:  state_d.rdata = {4'h0, state_q.flags};
        default: begin
          if (in_tbl) begin
            case (sub)
              `CLB_SUB_CTRL_A: state_d.rdata = state_q.tctl_a[tix];
              `CLB_SUB_INSEL:  state_d.rdata = state_q.tctl_b[tix];
              `CLB_SUB_INSEL2: state_d.rdata = state_q.tctl_c[tix];
              default:         state_d.rdata = state_q.truth[tix];
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  assign rdata_q             = state_q.rdata;
  assign table_output_q      = state_q.out;
  assign pin_out_q           = state_q.pin_out;
  assign pin_output_enable_q = state_q.oe;
  assign irq_q               = state_q.irq;

endmodule : clb_top
`default_nettype wire

// ---- rtl/clb_map.svh ----
// clb_map.svh: register offsets, field positions, codes and timing counts
// of the configurable logic block; definitions only, included by bare name.
`ifndef CLB_MAP_SVH
`define CLB_MAP_SVH

// register offsets (byte addresses on the plain port)
`define CLB_OFF_CTRL      5'h00
`define CLB_OFF_SEQ_LO    5'h01
`define CLB_OFF_SEQ_HI    5'h02
`define CLB_OFF_SENSE     5'h05
`define CLB_OFF_FLAGS     5'h07
`define CLB_OFF_TBL_FIRST 5'h08
`define CLB_OFF_TBL_LAST  5'h17
`define CLB_TBL_BASE_IDX  3'h2
// sub-offsets inside one table's group of four
`define CLB_SUB_CTRL_A    2'h0
`define CLB_SUB_INSEL     2'h1
`define CLB_SUB_INSEL2    2'h2
`define CLB_SUB_TRUTH     2'h3

// field positions
`define CLB_CTRL_EN       0
`define CLB_CTRL_STDBY    6
`define CLB_TA_EN         0
`define CLB_TA_CLK_LSB    1
`define CLB_TA_FILT_LSB   4
`define CLB_TA_OE         6
`define CLB_TA_EDGE       7
`define CLB_IN0_LSB       0
`define CLB_IN1_LSB       4

// reset value of every register
`define CLB_RST_VAL       8'h00

// sequencer codes
`define CLB_SEQ_OFF       4'h0
`define CLB_SEQ_DFF       4'h1
`define CLB_SEQ_JK        4'h2
`define CLB_SEQ_LATCH     4'h3
`define CLB_SEQ_RS        4'h4

// interrupt sense codes
`define CLB_SENSE_OFF     2'h0
`define CLB_SENSE_RISE    2'h1
`define CLB_SENSE_FALL    2'h2
`define CLB_SENSE_BOTH    2'h3

// output filter codes
`define CLB_FILT_OFF      2'h0
`define CLB_FILT_SYNC     2'h1
`define CLB_FILT_FILTER   2'h2
// filter: samples a new level must hold before it passes
`define CLB_FILT_LEN      2'h3

// table clock codes
`define CLB_CLK_SYS       3'h0
`define CLB_CLK_IN2       3'h1
`define CLB_CLK_FAST      3'h4
`define CLB_CLK_32K       3'h5
`define CLB_CLK_1K        3'h6

// input source codes
`define CLB_SRC_MASK      4'h0
`define CLB_SRC_FEEDBACK  4'h1
`define CLB_SRC_LINK      4'h2
`define CLB_SRC_EV_A      4'h3
`define CLB_SRC_EV_B      4'h4
`define CLB_SRC_PIN       4'h5
`define CLB_SRC_CMP       4'h6
`define CLB_SRC_SERIAL    4'h8
`define CLB_SRC_SPI       4'h9
`define CLB_SRC_TIMER_A   4'hA
`define CLB_SRC_TIMER_B   4'hC

`endif

// ---- rtl/clb_pkg.sv ----
// clb_pkg: carrier structs and state structs of the configurable logic block.
// assumes nothing beyond a SystemVerilog compiler.
package clb_pkg;

  // per-table signal sources; index k of a vector feeds table input k
  typedef struct packed {
    logic [2:0] pin;
    logic [2:0] serial_tx;
    logic [2:0] spi;
    logic [2:0] timer_a;
    logic [2:0] timer_b;
    logic       event_a;
    logic       event_b;
  } clb_src_s;

  // alternative table clocks
  typedef struct packed {
    logic fast;
    logic slow_32k;
    logic slow_1k;
  } clb_osc_s;

  // register port request
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } clb_bus_req_s;

  // state of one table's output conditioning
  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       filt;
    logic [1:0] cnt;
    logic       edge_prev;
  } clb_lut_state_s;

  // state of one pair sequencer
  typedef struct packed {
    logic q;
  } clb_seq_state_s;

endpackage : clb_pkg

// ---- rtl/clb_lut.sv ----
// clb_lut: truth lookup, output synchronizer or filter, and edge detector
// of one table; assumes tick is a one-cycle enable from the table's clock.
`timescale 1ns/1ps
`default_nettype none
`include "clb_map.svh"

module clb_lut (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // control
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic [7:0] truth,
  input  wire logic [1:0] filt_sel,
  input  wire logic       edge_en,
  // data
  input  wire logic [2:0] in_bits,
  output var  logic       cond_out
);
  import clb_pkg::*;

  clb_lut_state_s state_q;
  clb_lut_state_s state_d;
  logic           raw;
  logic           level;

  assign raw = truth[in_bits];

  always_comb begin
    case (filt_sel)
      `CLB_FILT_SYNC:   level = state_q.s2;
      `CLB_FILT_FILTER: level = state_q.filt;
      default:          level = raw;
    endcase
    cond_out = run && (edge_en ? (level & ~state_q.edge_prev) : level);
    state_d = state_q;
    if (!run) begin
      state_d = '0;
    end else if (tick) begin
      state_d.s1 = raw;
      state_d.s2 = state_q.s1;
      state_d.edge_prev = level;
      // a level must hold several samples before the filter follows it
      if (state_q.s2 == state_q.filt) begin
        state_d.cnt = 2'h0;
      end else if (state_q.cnt == `CLB_FILT_LEN - 2'h1) begin
        state_d.filt = state_q.s2;
        state_d.cnt = 2'h0;
      end else begin
        state_d.cnt = state_q.cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

endmodule : clb_lut
`default_nettype wire

// ---- rtl/clb_seq.sv ----
// clb_seq: sequencer shared by one pair of tables; even input a, odd input b.
// assumes tick comes from the even table's clock choice.
`timescale 1ns/1ps
`default_nettype none
`include "clb_map.svh"

module clb_seq (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // control
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic [3:0] mode,
  // data
  input  wire logic       a,
  input  wire logic       b,
  output var  logic       active,
  output var  logic       q
);
  import clb_pkg::*;

  clb_seq_state_s state_q;
  clb_seq_state_s state_d;

  always_comb begin
    state_d = state_q;
    active = 1'b1;
    case (mode)
      `CLB_SEQ_DFF: begin
        if (tick && b) begin
          state_d.q = a;
        end
      end
      `CLB_SEQ_JK: begin
        if (tick) begin
          case ({a, b})
            2'h2:    state_d.q = 1'b1;
            2'h1:    state_d.q = 1'b0;
            2'h3:    state_d.q = ~state_q.q;
            default: state_d.q = state_q.q;
          endcase
        end
      end
      // latches are level sensitive, so they follow every cycle
      `CLB_SEQ_LATCH: begin
        if (b) begin
          state_d.q = a;
        end
      end
      `CLB_SEQ_RS: begin
        if (a && !b) begin
          state_d.q = 1'b1;
        end else if (b && !a) begin
          state_d.q = 1'b0;
        end
      end
      default: begin
        active = 1'b0;
        state_d.q = 1'b0;
      end
    endcase
    if (!run) begin
      state_d.q = 1'b0;
    end
    q = state_q.q;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

endmodule : clb_seq
`default_nettype wire

// ---- tb/clb_top_monitor.sv ----
// clb_top_monitor: port-level checks of the logic block
// assumes a bind onto clb_top; ctrl and sense are shadowed from bus writes
`timescale 1ns/1ps
`default_nettype none
module clb_top_monitor (
  // clock and reset
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire logic                  ce,
  // register port and sleep
  input wire clb_pkg::clb_bus_req_s bus_req,
  input wire logic [7:0]            rdata_q,
  input wire logic                  standby,
  // outputs
  input wire logic [3:0]            table_output_q,
  input wire logic [3:0]            pin_out_q,
  input wire logic [3:0]            pin_output_enable_q,
  input wire logic                  irq_q
);
  import clb_pkg::*;
  logic       en_q;
  logic       rsb_q;
  logic [7:0] sense_q;
  logic       wr_ok;
  logic       sb_stop;
  logic       wr_flags;
  assign wr_ok = bus_req.wr && ce;
  assign wr_flags = wr_ok && bus_req.addr == 5'h07;
  assign sb_stop = standby && !rsb_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      en_q    <= 1'b0;
      rsb_q   <= 1'b0;
      sense_q <= 8'h00;
    end else begin
      if (wr_ok && bus_req.addr == 5'h00) begin
        en_q  <= bus_req.wdata[0];
        rsb_q <= bus_req.wdata[6];
      end
      if (wr_ok && bus_req.addr == 5'h05) sense_q <= bus_req.wdata;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_stopped_out_zero: assert property (!en_q [*3] |-> table_output_q == 4'h0 &&
    pin_output_enable_q == 4'h0) else $error("outputs active while disabled");
  a_standby_out_zero: assert property (sb_stop [*3] |-> table_output_q == 4'h0)
    else $error("outputs active in standby");
  a_pin_needs_enable: assert property ((pin_out_q & ~pin_output_enable_q) == 4'h0)
    else $error("pin driven without enable");
  a_irq_needs_change: assert property ($rose(irq_q) |-> table_output_q != $past(table_output_q))
    else $error("request without output change");
  a_irq_clear_cause: assert property ($fell(irq_q) |-> $past(wr_flags) || $past(wr_flags, 2))
    else $error("request dropped without flag write");
  a_no_sense_quiet: assert property (sense_q == 8'h00 && $past(sense_q) == 8'h00 |-> !$rose(irq_q))
    else $error("request with all senses off");
  a_read_idle_zero: assert property (!$past(bus_req.rd) |-> rdata_q == 8'h00)
    else $error("read data outside read cycle");
  a_ctrl_read_bits: assert property ($past(bus_req.rd && bus_req.addr == 5'h00) |->
    rdata_q == {1'h0, $past(rsb_q), 5'h00, $past(en_q)}) else $error("ctrl read wrong");
  a_reset_clears: assert property ($past(rst) |-> rdata_q == 8'h00 && irq_q == 1'b0 &&
    table_output_q == 4'h0) else $error("outputs not clear after reset");
  c_irq: cover property ($rose(irq_q));
  c_pin: cover property (pin_out_q[0]);
  c_read: cover property ($past(bus_req.rd) && rdata_q != 8'h00);
endmodule : clb_top_monitor
bind clb_top clb_top_monitor clb_top_monitor_i (.ref_clk, .rst, .ce, .bus_req, .rdata_q,
  .standby, .table_output_q, .pin_out_q, .pin_output_enable_q, .irq_q);
`default_nettype wire

// ---- tb/clb_src_model.sv ----
// clb_src_model: signal sources and oscillators around the logic block
// assumes pin levels come from the bench; serial peripherals act as hosts
`timescale 1ns/1ps
`default_nettype none
module clb_src_model (
  // bench control
  input  wire logic [3:0][2:0]         pin_lvl,
  // sources
  output var  clb_pkg::clb_src_s [3:0] src,
  output var  logic                    cmp,
  output var  clb_pkg::clb_osc_s       osc
);
  import clb_pkg::*;
  logic [2:0] host_q = 3'h0;
  initial osc = '0;
  always #5.3 osc.fast = ~osc.fast;
  always #61 osc.slow_32k = ~osc.slow_32k;
  always #301 osc.slow_1k = ~osc.slow_1k;
  // transmit lines keep moving, as a host would drive them
  always #7 host_q = host_q + 3'h1;
  assign cmp = host_q[1];
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      src[n].pin       = pin_lvl[n];
      src[n].serial_tx = host_q;
      src[n].spi       = ~host_q;
      src[n].timer_a   = {host_q[0], host_q[2:1]};
      src[n].timer_b   = host_q ^ 3'h5;
      src[n].event_a   = host_q[2];
      src[n].event_b   = host_q[0];
    end
  end
endmodule : clb_src_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// tb_top: self-checking bench for the logic block
// assumes the source model on the far side and a 125 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import clb_pkg::*;
  localparam logic [7:0] TT = 8'h96;
  logic            ref_clk = 1'b0;
  logic            rst     = 1'b1;
  clb_bus_req_s    bus_req = '0;
  logic            standby = 1'b0;
  logic [3:0][2:0] pin_lvl = '0;
  clb_src_s [3:0]  src;
  clb_osc_s        osc;
  logic            cmp;
  logic [7:0]      rdata_q;
  logic [3:0]      tout;
  logic [3:0]      pout;
  logic [3:0]      poe;
  logic            irq_q;
  int              n_errors = 0;
  int              n_tests  = 0;
  always #4 ref_clk = ~ref_clk;
  clb_src_model clb_src_model_i (.pin_lvl, .src, .cmp, .osc);
  clb_top clb_top_i (.ref_clk, .rst, .ce(1'b1), .bus_req, .rdata_q, .standby, .src,
    .analog_comparator_out(cmp), .osc, .table_output_q(tout), .pin_out_q(pout),
    .pin_output_enable_q(poe), .irq_q);
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
    @(posedge ref_clk);
  endtask : bus_wr
  task automatic bus_rd(input logic [4:0] a, input logic [7:0] exp);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 chk("register read", exp, rdata_q);
    @(posedge ref_clk);
  endtask : bus_rd
  // all four tables; protected, so only while the block is off
  task automatic cfg(input logic [7:0] c_ev, input logic [7:0] c_od);
    for (int n = 0; n < 4; n++) begin
      bus_wr(5'(8 + 4 * n), n[0] ? c_od : c_ev);
      bus_wr(5'(9 + 4 * n), 8'h55);
      bus_wr(5'(10 + 4 * n), 8'h05);
      bus_wr(5'(11 + 4 * n), TT);
    end
  endtask : cfg
  task automatic s_reset;
    logic [4:0] ra [8] = '{5'h00, 5'h01, 5'h02, 5'h05, 5'h07, 5'h08, 5'h17, 5'h03};
    foreach (ra[i]) bus_rd(ra[i], 8'h00);
    chk("outputs", 8'h00, {tout, poe});
  endtask : s_reset
  task automatic s_truth;
    cfg(8'h41, 8'h41);
    bus_wr(5'h00, 8'h01);
    for (int k = 0; k < 8; k++) begin
      pin_lvl[0] <= 3'(k);
      cyc(5);
      chk("table out", {5'h00, TT[k], TT[k], 1'b1}, {5'h00, tout[0], pout[0], poe[0]});
    end
    bus_wr(5'h0B, 8'hFF);
    bus_rd(5'h0B, TT);
    bus_wr(5'h01, 8'h01);
    bus_rd(5'h01, 8'h00);
    bus_wr(5'h00, 8'h00);
    cyc(4);
    chk("disabled", 8'h00, {tout, poe});
  endtask : s_truth
  task automatic s_standby;
    pin_lvl <= {4{3'h1}};
    cfg(8'h40, 8'h41);
    bus_wr(5'h00, 8'h01);
    cyc(5);
    chk("table enables", 8'h0A, {4'h0, tout});
    standby <= 1'b1;
    cyc(5);
    chk("standby stop", 8'h00, {4'h0, tout});
    bus_wr(5'h00, 8'h41);
    bus_rd(5'h00, 8'h41);
    cyc(4);
    chk("standby run", 8'h0A, {4'h0, tout});
    standby <= 1'b0;
    bus_wr(5'h00, 8'h00);
    pin_lvl <= '0;
  endtask : s_standby
  task automatic s_flags;
    cfg(8'h01, 8'h01);
    bus_wr(5'h00, 8'h01);
    for (int c = 0; c < 4; c++) begin
      bus_wr(5'h05, {6'h00, c[1:0]});
      bus_wr(5'h07, 8'h0F);
      pin_lvl[0] <= 3'h1;
      cyc(5);
      bus_rd(5'h07, {7'h00, c[0]});
      chk("request", {7'h00, c[0]}, {7'h00, irq_q});
      bus_wr(5'h07, 8'h0E);
      bus_rd(5'h07, {7'h00, c[0]});
      bus_wr(5'h07, 8'h01);
      bus_rd(5'h07, 8'h00);
      chk("request clear", 8'h00, {7'h00, irq_q});
      pin_lvl[0] <= 3'h0;
      cyc(5);
      bus_rd(5'h07, {7'h00, c[1]});
    end
    bus_wr(5'h07, 8'h0F);
    bus_wr(5'h00, 8'h00);
  endtask : s_flags
  // steps of (a, b) and expected even output per sequencer code
  task automatic s_seq;
    logic [4:0] av = 5'h09;
    logic [4:0] bv = 5'h0C;
    logic [4:0] ex [6] = '{5'h09, 5'h18, 5'h03, 5'h18, 5'h03, 5'h09};
    logic [4:0] mk [6] = '{5'h1F, 5'h1F, 5'h07, 5'h1F, 5'h1F, 5'h1F};
    cfg(8'h01, 8'h0F);
    for (int m = 0; m < 6; m++) begin
      bus_wr(5'h00, 8'h00);
      bus_wr(5'h01, 8'(m));
      bus_wr(5'h02, 8'(m));
      bus_wr(5'h00, 8'h01);
      for (int i = 0; i < 5; i++) begin
        pin_lvl <= {{2'h0, bv[i]}, {2'h0, av[i]}, {2'h0, bv[i]}, {2'h0, av[i]}};
        cyc(6);
        if (mk[m][i]) chk("low pair seq", {7'h00, ex[m][i]}, {7'h00, tout[0]});
        if (mk[m][i]) chk("high pair seq", {7'h00, ex[m][i]}, {7'h00, tout[2]});
      end
    end
    bus_wr(5'h00, 8'h00);
    bus_wr(5'h01, 8'h00);
    bus_wr(5'h02, 8'h00);
    pin_lvl <= '0;
  endtask : s_seq
  task automatic s_filter;
    int lat [4] = '{3, 5, 8, 3};
    int n;
    for (int f = 0; f < 5; f++) begin
      bus_wr(5'h00, 8'h00);
      bus_wr(5'h08, f < 4 ? {2'h0, f[1:0], 4'h1} : 8'h81);
      bus_wr(5'h00, 8'h01);
      cyc(4);
      pin_lvl[0] <= 3'h1;
      n = 0;
      if (f < 4) begin
        while (tout[0] !== 1'b1 && n < 20) begin
          @(posedge ref_clk);
          #1 n++;
        end
        chk("filter delay", 8'(lat[f]), 8'(n));
      end else begin
        repeat (12) begin
          @(posedge ref_clk);
          #1 n += int'(tout[0] === 1'b1);
        end
        chk("edge pulse", 8'h01, 8'(n));
      end
      pin_lvl[0] <= 3'h0;
      cyc(14);
    end
    bus_wr(5'h00, 8'h00);
  endtask : s_filter
  task automatic s_clock;
    bus_wr(5'h08, 8'h13);
    bus_wr(5'h00, 8'h01);
    for (int i = 0; i < 4; i++) begin
      pin_lvl[0] <= i[0] ? 3'h0 : 3'h4;
      cyc(6);
      chk("in2 clock", {7'h00, i > 1}, {7'h00, tout[0]});
    end
    bus_wr(5'h00, 8'h00);
  endtask : s_clock
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  initial begin
    cyc(16);
    rst <= 1'b0;
    cyc(1);
    s_reset;
    s_truth;
    s_standby;
    s_flags;
    s_seq;
    s_filter;
    s_clock;
    test_done;
  end
endmodule : tb_top
`default_nettype wire
